/* File: verilog/pmp_cfg.svh */
// pmp_cfg.svh: offsets, field positions, reset values and timing counts of the mii port
// assumes mclk at the rate given below; included by bare name
`ifndef PMP_CFG_SVH
`define PMP_CFG_SVH

`define PMP_MCLK_HZ          25000000
`define PMP_TXRX_10M_HZ      2500000
`define PMP_TXRX_100M_HZ     25000000
// half periods of the mii clocks in mclk cycles, never below one
`define PMP_HALF_10M         (((`PMP_MCLK_HZ / (2 * `PMP_TXRX_10M_HZ)) < 1) ? 1 : (`PMP_MCLK_HZ / (2 * `PMP_TXRX_10M_HZ)))
`define PMP_HALF_100M        (((`PMP_MCLK_HZ / (2 * `PMP_TXRX_100M_HZ)) < 1) ? 1 : (`PMP_MCLK_HZ / (2 * `PMP_TXRX_100M_HZ)))
`define PMP_RST_STRETCH_US   258
`define PMP_RST_STRETCH_CYC  ((`PMP_RST_STRETCH_US * `PMP_MCLK_HZ) / 1000000)

`define PMP_CTRL_ADDR        5'h00
`define PMP_CTRL_RESET_BIT   15
`define PMP_CTRL_SPEED_BIT   13
`define PMP_CTRL_DUPLEX_BIT  8
`define PMP_CTRL_RESET_VAL   16'h2000
`define PMP_PHYAD_UPPER      3'h0

`define PMP_PREAMBLE_LEN     6'h20
`define PMP_HDR_BITS         4'hc
`define PMP_DATA_BITS        5'h10
`define PMP_OP_READ          2'h2
`define PMP_OP_WRITE         2'h1

`endif

/* File: verilog/pmp_pkg.sv */
// pmp_pkg: types shared by the mii port design
// assumes pmp_cfg.svh holds every numeric constant
package pmp_pkg;
   typedef struct packed {
      logic       valid;
      logic       err;
      logic [3:0] nibble;
   } pmp_rx_line_s;

   typedef struct packed {
      logic       en;
      logic [3:0] nibble;
   } pmp_tx_pins_s;

   typedef enum logic [4:0] {
      MS_PRE = 5'h01,
      MS_ST  = 5'h02,
      MS_HDR = 5'h04,
      MS_TA  = 5'h08,
      MS_DAT = 5'h10
   } pmp_mdio_state_e;
endpackage

/* File: verilog/pmp_clk_div.sv */
// pmp_clk_div: divides mclk into a square clock and marks its edges with one-cycle enables
// assumes half is at least one and held stable except at speed changes
`timescale 1ns/1ps
`default_nettype none
module pmp_clk_div (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rst_n,
   // control
   input  wire logic       hold,
   input  wire logic [3:0] half,
   // outputs
   output logic            clk_out,
   output logic            rise_en,
   output logic            fall_en
);
   logic [3:0] cnt_reg;
   logic       last;

   assign last = (cnt_reg >= half - 4'h1);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_reg <= 4'h0;
         clk_out <= 1'b1;
         rise_en <= 1'b0;
         fall_en <= 1'b0;
      end else if (hold) begin
         // parked high while the port is in reset
         cnt_reg <= 4'h0;
         clk_out <= 1'b1;
         rise_en <= 1'b0;
         fall_en <= 1'b0;
      end else begin
         cnt_reg <= last ? 4'h0 : cnt_reg + 4'h1;
         rise_en <= last & ~clk_out;
         fall_en <= last & clk_out;
         if (last) begin
            clk_out <= ~clk_out;
         end
      end
   end
endmodule // pmp_clk_div
`default_nettype wire

/* File: verilog/pmp_mii_port.sv */
// pmp_mii_port: phy side of the mii, nibble paths, status pins, management slave and reset stretch
// assumes line-side inputs come from logic on mclk; every mii and management pin is asynchronous
//
// Overview of operation
// RQ1 - mac changes transmit nibble with transmit clock
// RQ2 - transmit bit zero is least significant
// RQ3 - mac raises transmit enable for valid nibbles
// RQ4 - phy makes transmit clock, 2.5 or 25 MHz; from a 25 MHz mclk the code gives 2.5 or 12.5 MHz
// RQ5 - phy makes receive clock, 25 or 2.5 MHz; from a 25 MHz mclk the code gives 12.5 or 2.5 MHz
// RQ6 - receive nibble changes on receive clock, lsb zero
// RQ7 - receive valid marks every valid data nibble
// RQ8 - receive error flags detected receive errors
// RQ9 - collision stays high while collision lasts
// RQ10 - collision inactive in full duplex
// RQ11 - half duplex: carrier on transmit or receive
// RQ12 - full duplex: carrier on receive only
// RQ13 - carrier rises anytime, falls with receive clock
// RQ14 - station keeps management clock at most 8 MHz
// RQ15 - management data pin shared, driven in turn
// RQ16 - reset pin or control bit resets phy
// RQ17 - internal reset stretched 258 us after release
// RQ18 - answer only accesses to strapped address
`include "pmp_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module pmp_mii_port import pmp_pkg::*; #(
   parameter int RST_STRETCH_CYC = `PMP_RST_STRETCH_CYC
) (
   // clock and reset
   input  wire logic         mclk,
   input  wire logic         rst_n,
   // mii transmit pins
   input  wire logic [3:0]   txd,
   input  wire logic         tx_en,
   output logic              tx_clk,
   // mii receive and status pins
   output logic [3:0]        rxd,
   output logic              rx_dv,
   output logic              rx_er,
   output logic              rx_clk,
   output logic              col,
   output logic              crs,
   // management pins
   input  wire logic         mdc,
   input  wire logic         mdio_in,
   output logic              mdio_out,
   output logic              mdio_oe_n,
   input  wire logic         phy_address_strap_bit0,
   input  wire logic         phy_address_strap_bit1,
   // line side
   input  wire pmp_rx_line_s line_rx,
   input  wire logic         line_carrier,
   input  wire logic         line_collision,
   output logic [3:0]        line_tx_nibble,
   output logic              line_tx_valid,
   // status
   output logic              speed_100,
   output logic              full_duplex,
   output logic              in_reset
);
   localparam logic [12:0] STRETCH = 13'(RST_STRETCH_CYC);

   logic [15:0]     ctrl_reg;
   logic            busy_reg;
   logic [12:0]     stretch_reg;
   logic            soft_rst;
   pmp_tx_pins_s    tx_s1_reg, tx_s2_reg;
   logic [2:0]      mdc_sync_reg;
   logic [1:0]      mdio_sync_reg;
   logic [1:0]      strap_s1_reg, strap_s2_reg;
   logic [4:0]      phyad_reg;
   logic            mdc_rise;
   logic            tx_fall, rx_rise;
   logic            tx_clk_w, rx_clk_w;
   logic [3:0]      half;
   pmp_mdio_state_e mstate_reg;
   logic [5:0]      ones_reg;
   logic [4:0]      bit_cnt_reg;
   logic [11:0]     hdr_reg;
   logic [15:0]     shift_reg;
   logic            is_read_reg;
   logic            mbit;
   logic            addr_hit;

   // pin synchronisers; only stage two and later are read by logic
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         tx_s1_reg     <= '0;
         tx_s2_reg     <= '0;
         mdc_sync_reg  <= 3'h0;
         mdio_sync_reg <= 2'h3;
         strap_s1_reg  <= 2'h0;
         strap_s2_reg  <= 2'h0;
      end else begin
         tx_s1_reg     <= '{en: tx_en, nibble: txd};
         tx_s2_reg     <= tx_s1_reg;
         mdc_sync_reg  <= {mdc_sync_reg[1:0], mdc};
         mdio_sync_reg <= {mdio_sync_reg[0], mdio_in};
         strap_s1_reg  <= {phy_address_strap_bit1, phy_address_strap_bit0};
         strap_s2_reg  <= strap_s1_reg;
      end
   end

   assign mdc_rise = mdc_sync_reg[1] & ~mdc_sync_reg[2];
   assign mbit     = mdio_sync_reg[1];

   // straps are caught throughout the internal reset and frozen afterwards
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         phyad_reg <= 5'h00;
      end else if (busy_reg) begin
         phyad_reg <= {`PMP_PHYAD_UPPER, strap_s2_reg}; // [RQ18]
      end
   end

   // reset stretch: pin and control bit share one counter
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         busy_reg    <= 1'b1;
         stretch_reg <= 13'h0000;
      end else if (soft_rst) begin
         busy_reg    <= 1'b1; // [RQ16]
         stretch_reg <= 13'h0000;
      end else if (busy_reg) begin
         if (stretch_reg >= STRETCH - 13'h1) begin
            busy_reg <= 1'b0; // [RQ17]
         end else begin
            stretch_reg <= stretch_reg + 13'h1;
         end
      end
   end

   // control register; reset bit reads back zero because busy reloads it
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_reg <= `PMP_CTRL_RESET_VAL;
      end else if (busy_reg) begin
         ctrl_reg <= `PMP_CTRL_RESET_VAL; // [RQ16]
      end else if (mdc_rise && mstate_reg == MS_DAT && !is_read_reg
                   && bit_cnt_reg == `PMP_DATA_BITS - 5'h1
                   && hdr_reg[4:0] == `PMP_CTRL_ADDR) begin
         ctrl_reg <= {shift_reg[14:0], mbit};
      end
   end

   assign soft_rst = !busy_reg && ctrl_reg[`PMP_CTRL_RESET_BIT];
   assign addr_hit = (hdr_reg[9:5] == phyad_reg);
   assign half     = ctrl_reg[`PMP_CTRL_SPEED_BIT] ? 4'(`PMP_HALF_100M) : 4'(`PMP_HALF_10M);

   // one divider per mii clock; both share hold and half, so the two run in phase
   pmp_clk_div u_tx_div ( // [RQ4]
      .clk     (mclk),
      .rst_n   (rst_n),
      .hold    (busy_reg),
      .half    (half),
      .clk_out (tx_clk_w),
      .rise_en (),
      .fall_en (tx_fall)
   );

   pmp_clk_div u_rx_div ( // [RQ5]
      .clk     (mclk),
      .rst_n   (rst_n),
      .hold    (busy_reg),
      .half    (half),
      .clk_out (rx_clk_w),
      .rise_en (rx_rise),
      .fall_en ()
   );

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         tx_clk <= 1'b1;
         rx_clk <= 1'b1;
      end else begin
         tx_clk <= tx_clk_w;
         rx_clk <= rx_clk_w;
      end
   end

   // transmit: the mac settles after the rising edge, so sample at mid-period
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         line_tx_nibble <= 4'h0;
         line_tx_valid  <= 1'b0;
      end else if (busy_reg) begin
         line_tx_nibble <= 4'h0;
         line_tx_valid  <= 1'b0;
      end else if (tx_fall) begin
         line_tx_valid  <= tx_s2_reg.en; // [RQ3]
         line_tx_nibble <= tx_s2_reg.en ? tx_s2_reg.nibble : 4'h0; // [RQ1] [RQ2]
      end
   end

   // receive nibble path, launched on the receive clock rising edge
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rxd   <= 4'h0;
         rx_dv <= 1'b0;
         rx_er <= 1'b0;
      end else if (busy_reg) begin
         rxd   <= 4'h0;
         rx_dv <= 1'b0;
         rx_er <= 1'b0;
      end else if (rx_rise) begin
         rxd   <= line_rx.valid ? line_rx.nibble : 4'h0; // [RQ6]
         rx_dv <= line_rx.valid; // [RQ7]
         rx_er <= line_rx.err; // [RQ8]
      end
   end

   // collision and carrier; carrier may rise at once but falls only on a receive edge
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         col <= 1'b0;
         crs <= 1'b0;
      end else if (busy_reg) begin
         col <= 1'b0;
         crs <= 1'b0;
      end else begin
         col <= line_collision & ~ctrl_reg[`PMP_CTRL_DUPLEX_BIT]; // [RQ9] [RQ10]
         if (line_carrier || (line_tx_valid && !ctrl_reg[`PMP_CTRL_DUPLEX_BIT])) begin
            crs <= 1'b1; // [RQ11] [RQ12]
         end else if (rx_rise) begin
            crs <= 1'b0; // [RQ13]
         end
      end
   end

   // management frame receiver; bits are taken on management clock rising edges
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         mstate_reg  <= MS_PRE;
         ones_reg    <= 6'h00;
         bit_cnt_reg <= 5'h00;
         hdr_reg     <= 12'h000;
         shift_reg   <= 16'h0000;
         is_read_reg <= 1'b0;
         mdio_out    <= 1'b1;
         mdio_oe_n   <= 1'b1;
      end else if (mdc_rise) begin
         case (mstate_reg)
            MS_PRE: begin
               if (mbit) begin
                  ones_reg <= (ones_reg == `PMP_PREAMBLE_LEN) ? ones_reg : ones_reg + 6'h01;
               end else begin
                  ones_reg <= 6'h00;
                  if (ones_reg == `PMP_PREAMBLE_LEN) begin
                     mstate_reg <= MS_ST;
                  end
               end
            end
            MS_ST: begin
               bit_cnt_reg <= 5'h00;
               mstate_reg  <= mbit ? MS_HDR : MS_PRE;
            end
            MS_HDR: begin
               hdr_reg     <= {hdr_reg[10:0], mbit};
               bit_cnt_reg <= bit_cnt_reg + 5'h01;
               if (bit_cnt_reg == 5'({1'b0, `PMP_HDR_BITS}) - 5'h01) begin
                  bit_cnt_reg <= 5'h00;
                  mstate_reg  <= MS_TA;
               end
            end
            MS_TA: begin
               if ({hdr_reg[10:9], mbit} != 3'h0 && !addr_hit) begin
                  mstate_reg <= MS_PRE; // [RQ18]
               end else if (hdr_reg[11:10] == `PMP_OP_READ && addr_hit) begin
                  is_read_reg <= 1'b1;
                  shift_reg   <= (hdr_reg[4:0] == `PMP_CTRL_ADDR) ? ctrl_reg : 16'h0000;
                  mdio_out    <= 1'b0; // [RQ15]
                  mdio_oe_n   <= 1'b0;
                  mstate_reg  <= MS_DAT;
               end else if (hdr_reg[11:10] == `PMP_OP_WRITE && addr_hit) begin
                  is_read_reg <= 1'b0;
                  bit_cnt_reg <= bit_cnt_reg + 5'h01;
                  if (bit_cnt_reg == 5'h01) begin
                     bit_cnt_reg <= 5'h00;
                     mstate_reg  <= MS_DAT;
                  end
               end else begin
                  mstate_reg <= MS_PRE;
               end
            end
            MS_DAT: begin
               bit_cnt_reg <= bit_cnt_reg + 5'h01;
               if (is_read_reg) begin
                  if (bit_cnt_reg == `PMP_DATA_BITS) begin
                     mdio_oe_n  <= 1'b1; // [RQ15]
                     mdio_out   <= 1'b1;
                     mstate_reg <= MS_PRE;
                  end else begin
                     mdio_out  <= shift_reg[15];
                     shift_reg <= {shift_reg[14:0], 1'b0};
                  end
               end else begin
                  shift_reg <= {shift_reg[14:0], mbit};
                  if (bit_cnt_reg == `PMP_DATA_BITS - 5'h1) begin
                     mstate_reg <= MS_PRE;
                  end
               end
            end
            default: begin
               mstate_reg <= MS_PRE;
            end
         endcase
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         speed_100   <= 1'b1;
         full_duplex <= 1'b0;
         in_reset    <= 1'b1;
      end else begin
         speed_100   <= ctrl_reg[`PMP_CTRL_SPEED_BIT];
         full_duplex <= ctrl_reg[`PMP_CTRL_DUPLEX_BIT];
         in_reset    <= busy_reg;
      end
   end

   property p_col_fd;
      @(posedge mclk) disable iff (!rst_n)
      $past(ctrl_reg[`PMP_CTRL_DUPLEX_BIT]) |-> !col;
   endproperty
   a_col_fd: assert property (p_col_fd) else $error("collision high in full duplex"); // [RQ10]

   property p_col_hold;
      @(posedge mclk) disable iff (!rst_n)
      (line_collision && !ctrl_reg[`PMP_CTRL_DUPLEX_BIT] && !busy_reg && !soft_rst) |=> col;
   endproperty
   a_col_hold: assert property (p_col_hold) else $error("collision not shown"); // [RQ9]

   property p_crs_fall;
      @(posedge mclk) disable iff (!rst_n)
      $fell(crs) |-> ($past(rx_rise) || $past(busy_reg));
   endproperty
   a_crs_fall: assert property (p_crs_fall) else $error("carrier dropped off receive edge"); // [RQ13]

   property p_crs_fd;
      @(posedge mclk) disable iff (!rst_n)
      ($rose(crs) && $past(ctrl_reg[`PMP_CTRL_DUPLEX_BIT])) |-> $past(line_carrier);
   endproperty
   a_crs_fd: assert property (p_crs_fd) else $error("carrier raised by transmit in full duplex"); // [RQ12]

   property p_crs_hd;
      @(posedge mclk) disable iff (!rst_n)
      (line_tx_valid && !ctrl_reg[`PMP_CTRL_DUPLEX_BIT] && !busy_reg && !soft_rst) |=> crs;
   endproperty
   a_crs_hd: assert property (p_crs_hd) else $error("no carrier during half duplex transmit"); // [RQ11]

   property p_rxd_sync;
      @(posedge mclk) disable iff (!rst_n)
      ($changed(rxd) || $changed(rx_dv) || $changed(rx_er)) |-> ($past(rx_rise) || $past(busy_reg));
   endproperty
   a_rxd_sync: assert property (p_rxd_sync) else $error("receive outputs moved off receive edge"); // [RQ6]

   property p_rxdv;
      @(posedge mclk) disable iff (!rst_n)
      (rx_rise && line_rx.valid && !busy_reg) |=> (rx_dv && rxd == $past(line_rx.nibble) && rx_er == $past(line_rx.err));
   endproperty
   a_rxdv: assert property (p_rxdv) else $error("receive nibble or valid wrong"); // [RQ7]

   property p_stretch;
      @(posedge mclk) disable iff (!rst_n)
      $fell(busy_reg) |-> $past(stretch_reg) == STRETCH - 13'h1;
   endproperty
   a_stretch: assert property (p_stretch) else $error("reset stretch length wrong"); // [RQ17]

   property p_soft_rst;
      @(posedge mclk) disable iff (!rst_n)
      soft_rst |=> (busy_reg && stretch_reg == 13'h0000) ##1 !ctrl_reg[`PMP_CTRL_RESET_BIT];
   endproperty
   a_soft_rst: assert property (p_soft_rst) else $error("control reset bit did not reset"); // [RQ16]

   property p_addr;
      @(posedge mclk) disable iff (!rst_n)
      $fell(mdio_oe_n) |-> $past(addr_hit);
   endproperty
   a_addr: assert property (p_addr) else $error("answered a foreign address"); // [RQ18]

   property p_clk_park;
      @(posedge mclk) disable iff (!rst_n)
      (busy_reg && $past(busy_reg)) |=> (tx_clk && rx_clk);
   endproperty
   a_clk_park: assert property (p_clk_park) else $error("mii clocks not high in reset"); // [RQ4]
endmodule // pmp_mii_port
`default_nettype wire

/* File: sim/pmp_mac_model.sv */
// pmp_mac_model: behavioural mac facing the phy side of the mii
// assumes tx_clk and rx_clk come from the phy; send is held until busy rises
`timescale 1ns/1ps
`default_nettype none
module pmp_mac_model (
   // mii clocks
   input  wire logic        tx_clk,
   input  wire logic        rx_clk,
   // receive pins
   input  wire logic [3:0]  rxd,
   input  wire logic        rx_dv,
   // bench control
   input  wire logic        send,
   input  wire logic [3:0]  len,
   input  wire logic [3:0]  gap,
   // transmit pins and status
   output logic [3:0]       txd,
   output logic             tx_en,
   output logic             busy,
   output logic [3:0]       rx_cnt,
   output logic [15:0]      rx_word
);
   logic [3:0] wait_reg;
   logic [3:0] idx_reg;
   initial begin
      txd = 4'h5;
      tx_en = 1'b0;
      busy = 1'b0;
      rx_cnt = 4'h0;
      rx_word = 16'h0;
      wait_reg = 4'h0;
      idx_reg = 4'h0;
   end
   // every change follows a tx_clk rise; gap gives a slow start
   always @(posedge tx_clk) begin
      if (send && !busy) begin
         busy <= 1'b1;
         wait_reg <= gap;
         idx_reg <= 4'h0;
      end else if (busy && wait_reg != 4'h0) begin
         wait_reg <= wait_reg - 4'h1;
      end else if (busy && idx_reg != len) begin
         tx_en <= 1'b1;
         txd <= idx_reg ^ 4'h9;
         idx_reg <= idx_reg + 4'h1;
      end else begin
         tx_en <= 1'b0;
         txd <= ~txd;                      // idle lines keep moving so stale data never passes for valid
         busy <= 1'b0;
      end
   end
   // sampled mid period, clear of the phy's change at the rise
   always @(negedge rx_clk) begin
      if (rx_dv === 1'b1) begin
         rx_word <= {rx_word[11:0], rxd};
         rx_cnt <= rx_cnt + 4'h1;
      end
   end
endmodule // pmp_mac_model
`default_nettype wire

/* File: sim/tb_pmp_mii_port.sv */
// tb_pmp_mii_port: self-checking bench for the mii port, mac model beside it, station tasks here
// assumes mclk 25 MHz; mdc made here at 320 ns, still between frames; mdio pulled up
`timescale 1ns/1ps
`default_nettype none
`include "pmp_cfg.svh"
module tb_pmp_mii_port import pmp_pkg::*;;
   localparam int STRETCH = 20;
   logic         mclk, rst_n, mdc, mdio_in, sta_oe, sta_d, send, line_carrier, line_collision;
   logic         tx_en, tx_clk, rx_dv, rx_er, rx_clk, col, crs, mdio_out, mdio_oe_n, busy;
   logic         line_tx_valid, speed_100, full_duplex, in_reset;
   logic [3:0]   txd, len, gap, rx_cnt, tx_cnt, rxd, line_tx_nibble;
   logic [15:0]  rx_word, tx_word, rd;
   pmp_rx_line_s line_rx;
   int           bad_count, num_checks, drove_n, er_n;

   // pull-up when neither side drives
   assign mdio_in = (mdio_oe_n === 1'b0) ? mdio_out : (sta_oe ? sta_d : 1'b1);

   pmp_mii_port #(.RST_STRETCH_CYC(STRETCH)) pmp_mii_port_i (
      .mclk(mclk), .rst_n(rst_n), .txd(txd), .tx_en(tx_en), .tx_clk(tx_clk), .rxd(rxd),
      .rx_dv(rx_dv), .rx_er(rx_er), .rx_clk(rx_clk), .col(col), .crs(crs), .mdc(mdc),
      .mdio_in(mdio_in), .mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n),
      .phy_address_strap_bit0(1'b0), .phy_address_strap_bit1(1'b1), .line_rx(line_rx),
      .line_carrier(line_carrier), .line_collision(line_collision),
      .line_tx_nibble(line_tx_nibble), .line_tx_valid(line_tx_valid),
      .speed_100(speed_100), .full_duplex(full_duplex), .in_reset(in_reset));

   pmp_mac_model pmp_mac_model_i (
      .tx_clk(tx_clk), .rx_clk(rx_clk), .rxd(rxd), .rx_dv(rx_dv), .send(send), .len(len),
      .gap(gap), .txd(txd), .tx_en(tx_en), .busy(busy), .rx_cnt(rx_cnt), .rx_word(rx_word));

   always #20 mclk = ~mclk;
   // running counts, one driver; tasks compare snapshots
   always @(posedge mclk) begin
      if (!rst_n) begin
         drove_n <= 0;
         er_n <= 0;
      end else begin
         if (mdio_oe_n === 1'b0) drove_n <= drove_n + 1;
         if (rx_err_now()) er_n <= er_n + 1;
      end
   end
   // line side taken at tx_clk rise, mid way through each held nibble
   always @(posedge tx_clk) begin
      if (line_tx_valid === 1'b1) begin
         tx_word <= {tx_word[11:0], line_tx_nibble};
         tx_cnt <= tx_cnt + 4'h1;
      end
   end

   function automatic logic rx_err_now();
      return rx_er === 1'b1;
   endfunction

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic end_sim();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   // one management bit: 4 mclk low, sample, 4 mclk high, i.e. 3.125 MHz
   task automatic mbit(input logic oe, input logic b, output logic s);
      sta_oe <= oe;
      sta_d <= b;
      repeat (4) @(posedge mclk);
      s = mdio_in;
      mdc <= 1'b1;
      repeat (4) @(posedge mclk);
      mdc <= 1'b0;
   endtask

   task automatic mframe(input logic [1:0] op, input logic [4:0] pa, input logic [15:0] wd,
                         output logic [15:0] q);
      logic        s;
      logic [13:0] hdr;
      hdr = {2'b01, op, pa, 5'h00};
      for (int i = 0; i < 32; i++) mbit(1'b1, 1'b1, s);
      for (int i = 13; i >= 0; i--) mbit(1'b1, hdr[i], s);
      mbit(op == `PMP_OP_WRITE, 1'b1, s);
      mbit(op == `PMP_OP_WRITE, 1'b0, s);  // station lets go of the line on a read
      for (int i = 15; i >= 0; i--) begin
         mbit(op == `PMP_OP_WRITE, wd[i], s);
         q[i] = s;
      end
      sta_oe <= 1'b0;
      repeat (8) @(posedge mclk);
   endtask

   task automatic clk_per(input logic use_tx, output int n);
      n = 0;
      while ((use_tx ? tx_clk : rx_clk) !== 1'b1) @(posedge mclk);
      while ((use_tx ? tx_clk : rx_clk) !== 1'b0) @(posedge mclk);
      while ((use_tx ? tx_clk : rx_clk) !== 1'b1) begin @(posedge mclk); n++; end
      while ((use_tx ? tx_clk : rx_clk) !== 1'b0) begin @(posedge mclk); n++; end
   endtask

   task automatic t_reset();
      int n;
      chk("pins in reset", 16'h00f9, {rxd, rx_dv, rx_er, col, crs, tx_clk, rx_clk, in_reset,
          mdio_oe_n, mdio_out, line_tx_valid, full_duplex, speed_100});
      rst_n <= 1'b1;
      n = 0;
      while (in_reset !== 1'b0 && n < 100) begin @(posedge mclk); n++; end
      chk("stretch in range", 16'h1, {15'h0, n >= STRETCH && n <= STRETCH + 3});
   endtask

   task automatic t_mgmt();
      int d0;
      d0 = drove_n;
      mframe(`PMP_OP_READ, 5'h02, 16'h0, rd);
      chk("ctrl read", `PMP_CTRL_RESET_VAL, rd);
      chk("phy drove mdio", 16'h1, {15'h0, drove_n != d0});
      chk("mdio released", 16'h1, {15'h0, mdio_oe_n});
      d0 = drove_n;
      mframe(`PMP_OP_READ, 5'h01, 16'h0, rd);
      chk("other address read", 16'hffff, rd);
      chk("phy silent", 16'h0, {15'h0, drove_n != d0});
   endtask

   // line_rx held one rx_clk period per nibble, so each is taken once whatever the phase
   task automatic t_rx(input int per);
      int         n;
      int         e0;
      logic [3:0] c0;
      clk_per(1'b0, n);
      chk("rx_clk period", 16'(per), 16'(n));
      clk_per(1'b1, n);
      chk("tx_clk period", 16'(per), 16'(n));
      c0 = rx_cnt;
      e0 = er_n;
      line_rx <= {1'b1, 1'b0, 4'h3};
      repeat (per) @(posedge mclk);
      line_rx <= {1'b1, 1'b1, 4'hc};
      repeat (per) @(posedge mclk);
      line_rx <= {1'b1, 1'b0, 4'h5};
      repeat (per) @(posedge mclk);
      line_rx <= {1'b0, 1'b0, 4'ha};
      repeat (4 * per) @(posedge mclk);
      chk("rx nibble count", {12'h0, c0 + 4'h3}, {12'h0, rx_cnt});
      chk("rx nibbles", 16'h03c5, {4'h0, rx_word[11:0]});
      chk("rx error seen", 16'h1, {15'h0, er_n != e0});
      chk("rx_dv idle", 16'h0, {15'h0, rx_dv});
   endtask

   task automatic t_tx_half();
      logic [3:0] c0;
      c0 = tx_cnt;
      len <= 4'h6;
      gap <= 4'h2;
      send <= 1'b1;
      while (busy !== 1'b1) @(posedge mclk);
      send <= 1'b0;
      while (tx_en !== 1'b1) @(posedge mclk);
      repeat (30) @(posedge mclk);
      chk("crs on own tx", 16'h1, {15'h0, crs});
      line_collision <= 1'b1;
      repeat (10) @(posedge mclk);
      chk("col held", 16'h1, {15'h0, col});
      line_collision <= 1'b0;
      repeat (3) @(posedge mclk);
      chk("col cleared", 16'h0, {15'h0, col});
      while (busy !== 1'b0) @(posedge mclk);
      repeat (40) @(posedge mclk);
      chk("tx nibble count", {12'h0, c0 + 4'h6}, {12'h0, tx_cnt});
      chk("tx nibbles", 16'hbadc, tx_word);
   endtask

   task automatic t_full();
      logic p, r;
      int   n;
      mframe(`PMP_OP_WRITE, 5'h02, 16'h0100, rd);
      chk("full_duplex", 16'h1, {15'h0, full_duplex});
      len <= 4'h4;
      gap <= 4'h0;
      send <= 1'b1;
      while (busy !== 1'b1) @(posedge mclk);
      send <= 1'b0;
      line_collision <= 1'b1;
      repeat (30) @(posedge mclk);
      chk("crs own tx full", 16'h0, {15'h0, crs});
      chk("col full", 16'h0, {15'h0, col});
      line_collision <= 1'b0;
      while (busy !== 1'b0) @(posedge mclk);
      repeat (30) @(posedge mclk);
      chk("tx nibbles full", 16'h98ba, tx_word);
      line_carrier <= 1'b1;
      repeat (3) @(posedge mclk);
      chk("crs on carrier", 16'h1, {15'h0, crs});
      line_carrier <= 1'b0;
      p = rx_clk;
      n = 0;
      while (crs !== 1'b0 && n < 40) begin p = rx_clk; @(posedge mclk); n++; end
      r = rx_clk;
      @(posedge mclk);
      chk("crs drop at rx_clk rise", 16'h1,
          {15'h0, (p === 1'b0 && r === 1'b1) || (r === 1'b0 && rx_clk === 1'b1)});
   endtask

   task automatic t_soft();
      mframe(`PMP_OP_WRITE, 5'h02, 16'h8100, rd);
      chk("soft reset active", 16'h1, {15'h0, in_reset});
      repeat (STRETCH + 10) @(posedge mclk);
      chk("soft reset over", 16'h0, {15'h0, in_reset});
      chk("duplex reloaded", 16'h0, {15'h0, full_duplex});
      mframe(`PMP_OP_READ, 5'h02, 16'h0, rd);
      chk("ctrl reloaded", `PMP_CTRL_RESET_VAL, rd);
   endtask

   initial begin
      mclk = 1'b0;
      rst_n = 1'b0;
      mdc = 1'b0;
      sta_oe = 1'b0;
      sta_d = 1'b1;
      send = 1'b0;
      len = 4'h0;
      gap = 4'h0;
      line_carrier = 1'b0;
      line_collision = 1'b0;
      line_rx = '0;
      tx_cnt = 4'h0;
      tx_word = 16'h0;
      bad_count = 0;
      num_checks = 0;
      repeat (5) @(posedge mclk);
      t_reset();
      t_mgmt();
      t_rx(2 * `PMP_HALF_100M);
      mframe(`PMP_OP_WRITE, 5'h02, 16'h0000, rd);
      chk("speed_100 cleared", 16'h0, {15'h0, speed_100});
      t_rx(2 * `PMP_HALF_10M);
      t_tx_half();
      t_full();
      t_soft();
      end_sim();
   end

   // about 4000 cycles of traffic expected; 25000 is a clear hang
   initial begin
      #1000000;
      bad_count++;
      $display("ERROR watchdog expected done seen timeout");
      end_sim();
   end
endmodule // tb_pmp_mii_port
`default_nettype wire
